// file: verilog/dowt_engine.sv
/*
 * Digital output waveform timing engine: sample FIFO, update clock
 * selection and division, start trigger, delay and line drivers.
 * Assumes timebase enables and internal signals on clk_i, and that the
 * host keeps the FIFO fed in streaming modes.
 */
// Notes on behaviour
// - Each active update edge drives next FIFO sample
// - Active update edge rising or falling, selectable
// - Update edge with empty FIFO flags underflow
// - Update clock selectable from internal signals
// - Any of sixteen lines can clock updates
// - Update clock exportable, inverted, on any line
// - Internal clock unless external; trigger starts engine
// - Start to first update delay, default two ticks
// - Internal clock divides timebase; timebase never exported
// - Timebase: 100 MHz default, 20 MHz, 100 kHz, line
// - Generation starts on trigger or software start
// - Retrigger replays full sample set per trigger
// - Triggers ignored while running; then await new
// - Trigger source and edge selectable
// - Start trigger exportable as high pulse
// - All lines are inputs after reset
// - Software timed: one update per command
// - Finite mode stops after preset count
// - Continuous mode runs until software stops
// - Regeneration: host restreams buffer into FIFO
// - Local replay: FIFO replays, refuses new data
// - Non-regeneration: no repeats, underflow when dry
`timescale 1ns/1ps
module dowt_engine
    import dowt_pkg::*;
#(
    parameter int NLINES = 16, // Digital lines and sample width
    parameter int DEPTH  = 16, // FIFO entries, power of two
    parameter int NINT   = 8,  // Internal clock candidates
    parameter int NTRG   = 8   // Internal trigger candidates
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Register port
    input  wire logic [5:0]        addr_i,
    input  wire logic [31:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [31:0]       rdata_o,
    // Timebase enables and internal routing
    input  wire logic              tb_100m_i,
    input  wire logic              tb_20m_i,
    input  wire logic              tb_100k_i,
    input  wire logic [NINT-1:0]   int_clk_i,
    input  wire logic [NTRG-1:0]   int_trg_i,
    // Digital lines
    input  wire logic [NLINES-1:0] dio_i,
    output logic      [NLINES-1:0] dio_o,
    output logic      [NLINES-1:0] dio_oe_n_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = AW + 1;

    // Elaboration check
    initial begin
        if (NLINES > 16 || NINT > 16 || NTRG > 16 || DEPTH < 2 ||
            (1 << AW) != DEPTH)
            $error("dowt_engine: unsupported parameters");
    end

    // Edge detection with polarity, used for clock, trigger, timebase
    function automatic logic edge_det(input logic prev, input logic cur,
                                      input logic fall);
        edge_det = fall ? (prev & ~cur) : (~prev & cur);
    endfunction

    // Configuration registers
    logic [7:0]        ctrl;     // Mode and polarity
    logic [15:0]       clkc;     // Clock routing
    logic [15:0]       divr;     // Divisor
    logic [15:0]       dlyr;     // Delay in timebase ticks
    logic [5:0]        trgc;     // Trigger routing
    logic [31:0]       cntr;     // Finite sample count
    logic [9:0]        expc;     // Exports
    logic [NLINES-1:0] dirr;     // Line directions

    // Engine state
    dowt_state_t       state;
    dowt_state_t       next_state;
    logic [15:0]       dly_cnt;  // Ticks spent in delay
    logic [15:0]       div_cnt;  // Divider phase
    logic              div_lvl;  // Divided clock level
    logic [31:0]       smp_cnt;  // Updates in this run
    logic              clk_prev; // Last update clock level
    logic              trg_prev; // Last trigger level
    logic              tbl_prev; // Last timebase line level
    logic              ufl;      // Sticky underflow
    logic              done;     // Sticky finite completion
    logic              trg_pls;  // Exported trigger pulse
    logic [NLINES-1:0] out_q;    // Driven sample

    // Line synchroniser, three stages
    logic [NLINES-1:0] dio_s1;
    logic [NLINES-1:0] dio_s2;
    logic [NLINES-1:0] dio_s3;
    logic [NLINES-1:0] dio_st;   // Accepted stable level

    // Sample FIFO
    logic [NLINES-1:0] mem [DEPTH];
    logic [AW-1:0]     wr_ptr;
    logic [AW-1:0]     rd_ptr;
    logic [AW-1:0]     rep_off;  // Replay offset from head
    logic [LW-1:0]     level;

    // Register port decode
    wire wr_ctrl = wr_i && addr_i == REG_CTRL;
    wire wr_clk  = wr_i && addr_i == REG_CLK;
    wire wr_div  = wr_i && addr_i == REG_DIV;
    wire wr_dly  = wr_i && addr_i == REG_DLY;
    wire wr_trg  = wr_i && addr_i == REG_TRIG;
    wire wr_cnt  = wr_i && addr_i == REG_CNT;
    wire wr_exp  = wr_i && addr_i == REG_EXP;
    wire wr_dir  = wr_i && addr_i == REG_DIR;
    wire wr_dat  = wr_i && addr_i == REG_DATA;
    wire wr_sta  = wr_i && addr_i == REG_STAT;
    wire wr_cmd  = wr_i && addr_i == REG_CMD;
    wire start_cmd = wr_cmd && wdata_i[CMD_STA];
    wire stop_cmd  = wr_cmd && wdata_i[CMD_STO];
    wire upd_cmd   = wr_cmd && wdata_i[CMD_UPD];

    // Field decode
    wire [1:0] mode    = ctrl[CTL_MODE +: 2];
    wire       replay  = ctrl[CTL_LOCAL];
    wire [1:0] ck_kind = clkc[CLK_KIND +: 2];
    wire [3:0] ck_int  = clkc[CLK_INT +: 4];
    wire [3:0] ck_line = clkc[CLK_LINE +: 4];
    wire [1:0] tb_sel  = clkc[CLK_TB +: 2];
    wire [3:0] tb_line = clkc[CLK_TBLN +: 4];
    wire [1:0] tr_src  = trgc[TRG_SRC +: 2];
    wire [3:0] tr_idx  = trgc[TRG_IDX +: 4];
    wire [15:0] dio_pad = 16'(dio_st);
    wire [15:0] ick_pad = 16'(int_clk_i);
    wire [15:0] itr_pad = 16'(int_trg_i);

    // Timebase select; no path leads it to a line
    wire tbl_lvl = dio_pad[tb_line];
    wire tb_tick = (tb_sel == TB_100M) ? tb_100m_i :
                   (tb_sel == TB_20M)  ? tb_20m_i  :
                   (tb_sel == TB_100K) ? tb_100k_i :
                   edge_det(tbl_prev, tbl_lvl, 1'b0);

    // Update clock source; divided timebase unless routed elsewhere
    wire clk_lvl = (ck_kind == KIND_INT) ? ick_pad[ck_int] :
                   (ck_kind == KIND_DIO) ? dio_pad[ck_line] :
                   div_lvl;
    wire clk_edge = edge_det(clk_prev, clk_lvl,
                             ctrl[CTL_CFALL]);
    wire upd_edge = (state == ST_RUN) && clk_edge;

    // Start trigger source and edge
    wire trg_lvl = (tr_src == TSRC_DIO) ? dio_pad[tr_idx] :
                   itr_pad[tr_idx];
    wire trg_edge = (tr_src == TSRC_HOST) ? start_cmd :
                    edge_det(trg_prev, trg_lvl,
                             ctrl[CTL_TFALL]);
    // Only the armed state listens, so running ignores triggers
    wire trg_acc = (state == ST_ARMED) && trg_edge
                   && !stop_cmd;

    // Software timed update, one per command
    wire sw_upd = upd_cmd && mode == MODE_SW
                  && state == ST_IDLE;

    // FIFO decode
    wire avail   = level != '0;
    wire full    = level == LW'(DEPTH);
    wire rep_run = replay && state == ST_RUN;
    // Local replay takes no data once a generation is under way
    wire push    = wr_dat && !full
                   && !(replay && state != ST_IDLE);
    wire pop_evt = (upd_edge || sw_upd) && avail;
    wire consume = pop_evt && !rep_run;
    wire [AW-1:0] head_idx = rd_ptr + (rep_run ? rep_off : '0);
    wire [NLINES-1:0] head = mem[head_idx];
    wire [AW-1:0] rep_nxt  = rep_off + 1'b1;
    wire fin_last = mode == MODE_FIN && upd_edge
                    && (smp_cnt + 32'h1) >= cntr;
    wire [15:0] eff_div = (divr < DIV_MIN) ? DIV_MIN : divr;

    // Next state of the engine
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (start_cmd && mode != MODE_SW)
                    next_state = ctrl[CTL_TRGEN] ? ST_ARMED
                                                 : ST_DELAY;
            end
            ST_ARMED: begin
                if (trg_acc)
                    next_state = ST_DELAY;
            end
            ST_DELAY: begin
                if (dly_cnt >= dlyr)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (fin_last)
                    next_state = ctrl[CTL_RETRG] ? ST_ARMED
                                                 : ST_IDLE;
            end
        endcase
        // Continuous runs leave only through this path
        if (stop_cmd)
            next_state = ST_IDLE;
    end

    // Configuration writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RST;
            clkc <= '0;
            divr <= DIV_RST;
            dlyr <= DLY_RST;
            trgc <= '0;
            cntr <= '0;
            expc <= '0;
            dirr <= '0;
        end else begin
            if (wr_ctrl) ctrl <= wdata_i[7:0];
            if (wr_clk)  clkc <= wdata_i[15:0];
            if (wr_div)  divr <= wdata_i[15:0];
            if (wr_dly)  dlyr <= wdata_i[15:0];
            if (wr_trg)  trgc <= wdata_i[5:0];
            if (wr_cnt)  cntr <= wdata_i;
            if (wr_exp)  expc <= wdata_i[9:0];
            if (wr_dir)  dirr <= wdata_i[NLINES-1:0];
        end
    end

    // Line synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dio_s1 <= '0;
            dio_s2 <= '0;
            dio_s3 <= '0;
            dio_st <= '0;
        end else begin
            dio_s1 <= dio_i;
            dio_s2 <= dio_s1;
            dio_s3 <= dio_s2;
            for (int i = 0; i < NLINES; i++)
                if (dio_s2[i] == dio_s3[i])
                    dio_st[i] <= dio_s3[i];
        end
    end

    // State, edge history and trigger export
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state    <= ST_IDLE;
            clk_prev <= 1'b0;
            trg_prev <= 1'b0;
            tbl_prev <= 1'b0;
            trg_pls  <= 1'b0;
        end else begin
            state    <= next_state;
            clk_prev <= clk_lvl;
            trg_prev <= trg_lvl;
            tbl_prev <= tbl_lvl;
            trg_pls  <= trg_acc;
        end
    end

    // Delay counter, in timebase ticks
    always_ff @(posedge clk_i) begin
        if (rst_i || state != ST_DELAY)
            dly_cnt <= '0;
        else if (tb_tick && dly_cnt != '1)
            dly_cnt <= dly_cnt + 16'h1;
    end

    // Timebase divider; the first pulse follows the delay at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= '0;
            div_lvl <= 1'b0;
        end else if (state != ST_RUN) begin
            div_cnt <= '0;
            div_lvl <= (state == ST_DELAY) && (next_state == ST_RUN);
        end else if (tb_tick) begin
            div_cnt <= (div_cnt == eff_div - 16'h1) ? '0
                       : div_cnt + 16'h1;
            div_lvl <= div_cnt == eff_div - 16'h1;
        end
    end

    // Sample count per run, cleared during the start delay
    always_ff @(posedge clk_i) begin
        if (rst_i || state == ST_DELAY)
            smp_cnt <= '0;
        else if (upd_edge)
            smp_cnt <= smp_cnt + 32'h1;
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ufl  <= 1'b0;
            done <= 1'b0;
        end else begin
            if ((upd_edge || sw_upd) && !avail)
                ufl <= 1'b1;
            else if (wr_sta && wdata_i[ST_UFL_B])
                ufl <= 1'b0;
            if (fin_last)
                done <= 1'b1;
            else if (start_cmd)
                done <= 1'b0;
        end
    end

    // FIFO storage; host restreaming is ordinary pushes
    always_ff @(posedge clk_i) begin
        if (push)
            mem[wr_ptr] <= wdata_i[NLINES-1:0];
    end

    // FIFO pointers and replay offset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            rep_off <= '0;
            level   <= '0;
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (consume)
                rd_ptr <= rd_ptr + 1'b1;
            level <= level + LW'(push) - LW'(consume);
            if (!rep_run)
                rep_off <= '0;
            else if (pop_evt)
                rep_off <= (LW'(rep_nxt) == level) ? '0
                           : rep_nxt;
        end
    end

    // Output sample; held when no update edge or software update command takes a sample
    always_ff @(posedge clk_i) begin
        if (rst_i)
            out_q <= '0;
        else if (pop_evt)
            out_q <= head;
    end

    // Line drivers; exports override the sample on their line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dio_o      <= '0;
            dio_oe_n_o <= '1;
        end else begin
            for (int i = 0; i < NLINES; i++) begin
                if (expc[EXP_CEN] && expc[EXP_CLN +: 4] == 4'(i)) begin
                    dio_o[i]      <= ~clk_lvl;
                    dio_oe_n_o[i] <= 1'b0;
                end else if (expc[EXP_TEN]
                             && expc[EXP_TLN +: 4] == 4'(i)) begin
                    dio_o[i]      <= trg_pls;
                    dio_oe_n_o[i] <= 1'b0;
                end else begin
                    dio_o[i]      <= out_q[i];
                    dio_oe_n_o[i] <= ~dirr[i];
                end
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    wire [31:0] stat_w = {{(32-ST_LVL-LW){1'b0}}, level, 3'h0, ~avail,
                          full, done, ufl, state != ST_IDLE};
    wire [31:0] rd_mux =
        (addr_i == REG_CTRL) ? 32'(ctrl) :
        (addr_i == REG_CLK)  ? 32'(clkc) :
        (addr_i == REG_DIV)  ? 32'(divr) :
        (addr_i == REG_DLY)  ? 32'(dlyr) :
        (addr_i == REG_TRIG) ? 32'(trgc) :
        (addr_i == REG_CNT)  ? cntr      :
        (addr_i == REG_EXP)  ? 32'(expc) :
        (addr_i == REG_DIR)  ? 32'(dirr) :
        (addr_i == REG_DATA) ? 32'(out_q) :
        (addr_i == REG_STAT) ? stat_w    : 32'h0;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            rdata_o <= '0;
        else
            rdata_o <= rd_i ? rd_mux : 32'h0;
    end

    // Checks on the engine
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_UFL_SET: assert property (
        (upd_edge && !avail) |=> ufl)
        else $error("update on empty FIFO left underflow clear");
    AST_POP_DRIVE: assert property (
        pop_evt |=> out_q == $past(head))
        else $error("update edge did not drive the head sample");
    AST_HOLD: assert property (
        !pop_evt |=> $stable(out_q))
        else $error("output changed without an update");
    AST_OE_RESET: assert property (disable iff (1'b0)
        rst_i |=> dio_oe_n_o == '1)
        else $error("line driven after reset");
    AST_IGNORE_TRG: assert property (
        (state == ST_RUN && !fin_last) |=> state != ST_DELAY)
        else $error("trigger restarted a running sequence");
    AST_FIN_STOP: assert property (
        (fin_last && !stop_cmd) |=> state == ST_IDLE || state == ST_ARMED)
        else $error("finite run did not stop at its count");
    AST_CONT_RUN: assert property (
        (state == ST_RUN && mode == MODE_CONT && !stop_cmd
         && !wr_ctrl) |=> state == ST_RUN)
        else $error("continuous run ended without a stop");
    AST_DELAY: assert property (
        (state == ST_DELAY && next_state == ST_RUN && !stop_cmd)
        |-> dly_cnt >= dlyr)
        else $error("first update came before the delay");
    AST_TRG_OUT: assert property (
        (trg_acc && expc[EXP_TEN] && !(expc[EXP_CEN]
         && expc[EXP_CLN +: 4] == expc[EXP_TLN +: 4]))
        |=> ##1 dio_o[expc[EXP_TLN +: 4]])
        else $error("accepted trigger not exported");
    AST_REPLAY_LVL: assert property (
        (replay && state == ST_RUN) |=> $stable(level) || state != ST_RUN)
        else $error("local replay changed the FIFO fill");
    AST_SW_ONE: assert property (
        (mode == MODE_SW && state == ST_IDLE) |->
        ($changed(rd_ptr) -> $past(sw_upd)))
        else $error("software timed update without a command");

    COV_FINITE: cover property (fin_last ##1 state == ST_IDLE);
    COV_RETRIG: cover property (fin_last ##1 state == ST_ARMED);
    COV_UNDER:  cover property (upd_edge && !avail);
    COV_SWUPD:  cover property (sw_upd && avail);
endmodule // dowt_engine

// file: verilog/dowt_pkg.sv
/*
 * Constants for the digital output waveform timing engine: register
 * offsets, field positions, reset values, encodings and states.
 * Assumes a 32-bit register port with byte addresses on word bounds.
 */
package dowt_pkg;
    // Register byte offsets
    localparam logic [5:0] REG_CTRL = 6'h00; // Mode and polarity setup
    localparam logic [5:0] REG_CLK  = 6'h04; // Update clock routing
    localparam logic [5:0] REG_DIV  = 6'h08; // Timebase divisor
    localparam logic [5:0] REG_DLY  = 6'h0c; // Trigger to first update
    localparam logic [5:0] REG_TRIG = 6'h10; // Start trigger routing
    localparam logic [5:0] REG_CNT  = 6'h14; // Finite sample count
    localparam logic [5:0] REG_EXP  = 6'h18; // Export of timing signals
    localparam logic [5:0] REG_DIR  = 6'h1c; // Line direction, 1 = out
    localparam logic [5:0] REG_DATA = 6'h20; // Sample push / last sample
    localparam logic [5:0] REG_STAT = 6'h24; // Status, write 1 clears underflow
    localparam logic [5:0] REG_CMD  = 6'h28; // Command pulses

    // Control fields
    localparam int CTL_MODE  = 0;  // Two bits: sample mode
    localparam int CTL_RETRG = 2;  // Retriggerable generation
    localparam int CTL_CFALL = 3;  // Update on falling clock edge
    localparam int CTL_TFALL = 4;  // Trigger on falling edge
    localparam int CTL_TRGEN = 5;  // Wait for a start trigger
    localparam int CTL_REGEN = 6;  // Repeat buffer setting
    localparam int CTL_LOCAL = 7;  // Local replay setting
    localparam logic [7:0] CTRL_RST = 8'h40;

    // Sample modes
    localparam logic [1:0] MODE_SW   = 2'h0; // Software timed
    localparam logic [1:0] MODE_FIN  = 2'h1; // Finite
    localparam logic [1:0] MODE_CONT = 2'h2; // Continuous

    // Clock routing fields and source kinds
    localparam int CLK_KIND = 0;  // Two bits
    localparam int CLK_INT  = 2;  // Four bits: internal signal index
    localparam int CLK_LINE = 6;  // Four bits: line as update clock
    localparam int CLK_TB   = 10; // Two bits: timebase select
    localparam int CLK_TBLN = 12; // Four bits: line as timebase
    localparam logic [1:0] KIND_DIV = 2'h0;
    localparam logic [1:0] KIND_INT = 2'h1;
    localparam logic [1:0] KIND_DIO = 2'h2;
    localparam logic [1:0] TB_100M  = 2'h0; // Default after reset
    localparam logic [1:0] TB_20M   = 2'h1;
    localparam logic [1:0] TB_100K  = 2'h2;
    localparam logic [1:0] TB_DIO   = 2'h3;

    // Trigger routing fields and sources
    localparam int TRG_SRC = 0;   // Two bits
    localparam int TRG_IDX = 2;   // Four bits
    localparam logic [1:0] TSRC_HOST = 2'h0;
    localparam logic [1:0] TSRC_DIO  = 2'h1;
    localparam logic [1:0] TSRC_INT  = 2'h2;

    // Export fields
    localparam int EXP_CLN = 0;   // Four bits: clock line
    localparam int EXP_CEN = 4;
    localparam int EXP_TLN = 5;   // Four bits: trigger line
    localparam int EXP_TEN = 9;

    // Status and command bits
    localparam int ST_RUN_B = 0;
    localparam int ST_UFL_B = 1;
    localparam int ST_DONE  = 2;
    localparam int ST_FULL  = 3;
    localparam int ST_EMPTY = 4;
    localparam int ST_LVL   = 8;
    localparam int CMD_STA  = 0;
    localparam int CMD_STO  = 1;
    localparam int CMD_UPD  = 2;

    // Reset values
    localparam logic [15:0] DLY_RST = 16'h0002; // Two timebase ticks
    localparam logic [15:0] DIV_RST = 16'h0002;
    localparam logic [15:0] DIV_MIN = 16'h0002;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_DELAY = 2'b11,
        ST_RUN   = 2'b10
    } dowt_state_t;
endpackage

// file: tb/dowt_line_model.sv
/* Far side equipment on the digital lines: resolves each line.
   Assumes oe_n low means the engine drives that line. */
`timescale 1ns/1ps
module dowt_line_model (
    // Engine side
    input  wire logic [15:0] dio_o,
    input  wire logic [15:0] dio_oe_n_o,
    // Equipment's own changing pattern
    input  wire logic [15:0] ext_i,
    output logic      [15:0] wire_o
);
    // Lines the engine leaves as inputs show the equipment level
    assign wire_o = (dio_o & ~dio_oe_n_o) | (ext_i & dio_oe_n_o);
endmodule // dowt_line_model

// file: tb/dowt_engine_tb.sv
/* Bench for the output waveform engine: register tasks and sequences.
   Assumes the register map of the package and a 100 MHz tick each cycle. */
`timescale 1ns/1ps
module dowt_engine_tb;
    import dowt_pkg::*;
    logic        clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
    logic [5:0]  addr_i = 0;
    logic [31:0] wdata_i = 0, rdata_o, got;
    logic        tb_20m_i = 0, tb_100k_i = 0;
    logic [7:0]  int_clk_i = 0, int_trg_i = 0, prev;
    logic [15:0] dio_o, dio_oe_n_o, lines, ext = 16'h3c00;
    logic [7:0]  q[$];
    int          failures = 0, n_tests = 0, cyc = 0, hits = 0;
    always #4 clk_i = ~clk_i;
    // Slow ticks, a moving far side and the hang limit
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        tb_20m_i <= (cyc % 5 == 0);
        tb_100k_i <= (cyc % 1000 == 0);
        ext <= {ext[14:0], ext[15]};
        if (cyc == 5000) begin
            failures = failures + 1;
            end_sim();
        end
    end
    dowt_engine i_dowt_engine (.clk_i(clk_i), .rst_i(rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .tb_100m_i(1'b1), .tb_20m_i(tb_20m_i),
        .tb_100k_i(tb_100k_i), .int_clk_i(int_clk_i),
        .int_trg_i(int_trg_i), .dio_i(lines), .dio_o(dio_o),
        .dio_oe_n_o(dio_oe_n_o));
    dowt_line_model i_dowt_line_model (.dio_o(dio_o),
        .dio_oe_n_o(dio_oe_n_o), .ext_i(ext), .wire_o(lines));
    // One-cycle write strobe
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data is taken in the one cycle after the strobe
    task automatic rd(input logic [5:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        got = rdata_o;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(16'hffff, dio_oe_n_o);
        rd(REG_CTRL);
        chk(CTRL_RST, got);
        rd(REG_CLK);
        chk(32'h0, got);
        rd(REG_DIV);
        chk(DIV_RST, got);
        rd(REG_DLY);
        chk(DLY_RST, got);
        rd(6'h3c);
        chk(32'h0, got);
        // Software timed: one update per command, held otherwise
        wr(REG_DIR, 32'h00ff);
        wr(REG_DATA, 32'h12a5);
        wr(REG_DATA, 32'h125a);
        wr(REG_CMD, 32'h4);
        repeat (6) @(posedge clk_i);
        chk(16'hff00, dio_oe_n_o);
        chk(8'ha5, lines[7:0]);
        repeat (6) @(posedge clk_i);
        chk(8'ha5, dio_o[7:0]);
        wr(REG_CMD, 32'h4);
        wr(REG_CMD, 32'h4);
        rd(REG_STAT);
        chk(32'h1 << ST_UFL_B | 32'h1 << ST_EMPTY, got);
        chk(8'h5a, dio_o[7:0]);
        wr(REG_STAT, 32'h2);
        // Finite runs: rising edge, falling edge behind host trigger,
        // then a retrigger replaying the full set
        for (int k = 0; k < 3; k++) begin
            wr(REG_CNT, 32'h3);
            for (int s = 1; s < 4; s++) wr(REG_DATA, 32'(s));
            if (k < 2)
                wr(REG_CTRL, 32'(MODE_FIN) | 32'(k << CTL_CFALL
                   | k << CTL_TRGEN | k << CTL_RETRG));
            if (k < 2) wr(REG_CMD, 32'h1);
            if (k > 0) wr(REG_CMD, 32'h1);
            q = {};
            prev = dio_o[7:0];
            repeat (80) begin
                @(posedge clk_i);
                if (dio_o[7:0] !== prev) q.push_back(dio_o[7:0]);
                prev = dio_o[7:0];
            end
            chk(32'd3, q.size());
            for (int s = 0; s < 3; s++) chk(s + 1, q[s]);
            rd(REG_STAT);
            chk(32'h1 << ST_DONE | 32'h1 << ST_EMPTY
                | 32'(k > 0) << ST_RUN_B, got);
        end
        // Continuous local replay on an internal clock, both exports on
        wr(REG_CMD, 32'h2);
        for (int s = 1; s < 3; s++) wr(REG_DATA, 32'(s * 8'h11));
        wr(REG_CLK, 32'(KIND_INT) | 32'h2 << CLK_INT);
        wr(REG_EXP, 32'h8 | 32'h1 << EXP_CEN | 32'h9 << EXP_TLN
           | 32'h1 << EXP_TEN);
        wr(REG_TRIG, 32'(TSRC_INT) | 32'h3 << TRG_IDX);
        wr(REG_CTRL, 32'(MODE_CONT) | 32'h1 << CTL_TRGEN
           | 32'h1 << CTL_LOCAL);
        wr(REG_CMD, 32'h1);
        int_trg_i <= 8'h08;
        q = {};
        prev = dio_o[7:0];
        for (int j = 0; j < 40; j++) begin
            @(posedge clk_i);
            hits = hits + dio_o[9];
            if (dio_o[7:0] !== prev) q.push_back(dio_o[7:0]);
            prev = dio_o[7:0];
            if (j % 4 == 3) int_clk_i <= int_clk_i ^ 8'h04;
            if (j == 20 || j == 24) int_trg_i <= int_trg_i ^ 8'h08;
        end
        chk(32'd1, hits);
        chk(32'd5, q.size());
        for (int s = 0; s < 5; s++) chk(s % 2 ? 8'h22 : 8'h11, q[s]);
        wr(REG_DATA, 32'h33);
        rd(REG_STAT);
        chk(32'h2 << ST_LVL | 32'h1 << ST_RUN_B, got);
        chk(!int_clk_i[2], dio_o[8]);
        chk(32'h0, dio_oe_n_o[9:8]);
        wr(REG_CMD, 32'h2);
        rd(REG_STAT);
        chk(32'h2 << ST_LVL, got);
        end_sim();
    end
endmodule // dowt_engine_tb
